/* gis_pkg.sv */
// Shared constants, carriers and state layout for the interrupt source selector
package gis_pkg;

   // Widths
   localparam int GIS_DW       = 8;
   localparam int GIS_AW       = 24;
   localparam int GIS_AD_LINES = 8;
   localparam int GIS_PC_LINES = 4;
   localparam int GIS_LINES    = 12;
   localparam int GIS_EXC_W    = 4;
   localparam int GIS_PRIO_W   = 2;
   localparam int GIS_PINS_W   = 21;

   // Documented register offsets
   localparam logic [23:0] GIS_OFS_ALT_SRC  = 24'hFFE10C;
   localparam logic [23:0] GIS_OFS_PORT_SEL = 24'hFFE10E;
   localparam logic [23:0] GIS_OFS_EDGE_SEL = 24'hFFE10F;
   localparam logic [23:0] GIS_OFS_PC_SEL   = 24'hFFE12E;

   // Controller registers
   localparam logic [23:0] GIS_OFS_STAT_LO  = 24'hFFE0E0;
   localparam logic [23:0] GIS_OFS_STAT_HI  = 24'hFFE0E1;
   localparam logic [23:0] GIS_OFS_SET_LO   = 24'hFFE0E2;
   localparam logic [23:0] GIS_OFS_SET_HI   = 24'hFFE0E3;
   localparam logic [23:0] GIS_OFS_EN_LO    = 24'hFFE0E4;
   localparam logic [23:0] GIS_OFS_EN_HI    = 24'hFFE0E5;
   localparam logic [23:0] GIS_OFS_PRIO0    = 24'hFFE0E6;
   localparam logic [23:0] GIS_OFS_PRIO1    = 24'hFFE0E7;
   localparam logic [23:0] GIS_OFS_PRIO2    = 24'hFFE0E8;
   localparam logic [23:0] GIS_OFS_CTRL     = 24'hFFE0E9;
   localparam logic [23:0] GIS_OFS_EXC_STAT = 24'hFFE0EA;

   // Field positions and writable masks
   localparam int          GIS_CMP_BIT     = 7;
   localparam int          GIS_DBG_BIT     = 0;
   localparam int          GIS_POLL_BIT    = 0;
   localparam logic [7:0]  GIS_ALT_WR_MASK = 8'h81;
   localparam logic [7:0]  GIS_PC_WR_MASK  = 8'h0F;
   localparam logic [1:0]  GIS_PRIO_TOP    = 2'h2;

   // Values after reset
   localparam logic [7:0]  GIS_REG_RST     = 8'h00;
   localparam logic [11:0] GIS_LINES_RST   = 12'h000;
   localparam logic [23:0] GIS_PRIO_RST    = 24'h000000;
   localparam logic [3:0]  GIS_EXC_RST     = 4'h0;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [23:0] addr;
      logic [7:0]  wdata;
   } gis_bus_req_s;

   typedef struct packed {
      logic       cmp;
      logic [3:0] port_c;
      logic [7:0] port_d;
      logic [7:0] port_a;
   } gis_pins_s;

   typedef struct packed {
      logic       valid;
      logic [1:0] level;
      logic [3:0] line;
   } gis_vec_s;

   typedef struct packed {
      logic [7:0]  alt_src;
      logic [7:0]  port_sel;
      logic [7:0]  edge_sel;
      logic [7:0]  pc_sel;
      logic [11:0] status;
      logic [11:0] enable;
      logic [23:0] prio;
      logic        polled;
      logic [3:0]  exc_status;
      logic [7:0]  rdata;
      logic [11:0] req_pulse;
      gis_vec_s    vec;
   } gis_state_s;

   localparam gis_state_s GIS_STATE_RST = '{
      alt_src:    GIS_REG_RST,
      port_sel:   GIS_REG_RST,
      edge_sel:   GIS_REG_RST,
      pc_sel:     GIS_REG_RST,
      status:     GIS_LINES_RST,
      enable:     GIS_LINES_RST,
      prio:       GIS_PRIO_RST,
      polled:     1'b0,
      exc_status: GIS_EXC_RST,
      rdata:      GIS_REG_RST,
      req_pulse:  GIS_LINES_RST,
      vec:        '0
   };

endpackage

/* gis_sync_edge.sv */
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module gis_sync_edge
   import gis_pkg::*;
#(
   parameter int W = GIS_PINS_W
) (
   // Clock, reset, enable
   input  wire logic         core_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         ce_in,
   // Asynchronous pins
   input  wire logic [W-1:0] pin_in,
   // Edge pulses
   output logic      [W-1:0] rise_out,
   output logic      [W-1:0] fall_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] prev;
   } gis_se_state_s;

   gis_se_state_s st_r;
   gis_se_state_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.s1   = pin_in;
      st_nxt.s2   = st_r.s1;
      st_nxt.prev = st_r.s2;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // Edges seen only after both stages
   assign rise_out = st_r.s2 & ~st_r.prev; // R14
   assign fall_out = ~st_r.s2 & st_r.prev; // R14

endmodule
`default_nettype wire

/* gis_irq_sel.sv */
// Interrupt source selection and request controller
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1 - Comparator bit set routes comparator to line 7, clear routes pin 7 edge
// R2 - Debug bit set routes debugger request to line 0, clear routes pin 0
// R3 - Software writes zeros to alternate-source bits 6 to 1
// R4 - Port-select bit picks Port A pin at 0, Port D pin at 1
// R5 - Edge bit picks falling edge at 0, rising edge at 1
// R6 - Port C selection bit passes DMA request at 0, pin event at 1
// R7 - Software writes zeros to Port C selection bits 7 to 4
// R8 - Eight single-edge selectable lines plus four lines firing on both edges
// R9 - Each request line gets one of three programmable priority levels
// R10 - Software may assert any request line directly
// R11 - Exception requests ignore masks and polling and always signal the CPU
// R12 - In polled mode vectoring stops while request flags stay readable
// R13 - Comparator on line 7 raises requests on both transitions
// R14 - Pins synchronised before edge detection; each edge gives one-cycle pulse
module gis_irq_sel
   import gis_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ce_in,
   // Register port
   input  wire gis_bus_req_s         bus_in,
   output logic      [GIS_DW-1:0]    rdata_out,
   // Asynchronous sources
   input  wire gis_pins_s            pins_in,
   // Same-clock sources
   input  wire logic                 dbg_req_in,
   input  wire logic [3:0]           dma_req_in,
   input  wire logic [GIS_EXC_W-1:0] exc_req_in,
   // CPU acknowledge
   input  wire logic                 ack_in,
   input  wire logic [3:0]           ack_line_in,
   // Requests toward the CPU
   output logic      [GIS_LINES-1:0] line_req_out,
   output logic                      irq_out,
   output gis_vec_s                  vec_out,
   output logic                      exc_out
);

   gis_state_s          st_r;
   gis_state_s          st_nxt;
   logic [GIS_PINS_W-1:0] rise;
   logic [GIS_PINS_W-1:0] fall;
   logic [GIS_LINES-1:0]  ev;

   gis_sync_edge #(
      .W (GIS_PINS_W)
   ) u_sync_edge (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .ce_in       (ce_in),
      .pin_in      (pins_in),
      .rise_out    (rise),
      .fall_out    (fall)
   );

   // Pin bit positions inside the synchronised vector
   localparam int PA0  = 0;
   localparam int PD0  = 8;
   localparam int PC0  = 16;
   localparam int PCMP = 20;

   // Source selection per request line
   always_comb begin
      logic r_sel;
      logic f_sel;
      r_sel = 1'b0;
      f_sel = 1'b0;
      ev    = '0;
      for (int i = 0; i < GIS_AD_LINES; i++) begin
         r_sel = st_r.port_sel[i] ? rise[PD0+i] : rise[PA0+i]; // R4
         f_sel = st_r.port_sel[i] ? fall[PD0+i] : fall[PA0+i]; // R4
         ev[i] = st_r.edge_sel[i] ? r_sel : f_sel; // R5 R8
      end
      if (st_r.alt_src[GIS_CMP_BIT]) begin
         ev[7] = rise[PCMP] | fall[PCMP]; // R1 R13
      end
      if (st_r.alt_src[GIS_DBG_BIT]) begin
         ev[0] = dbg_req_in; // R2
      end
      for (int j = 0; j < GIS_PC_LINES; j++) begin
         ev[GIS_AD_LINES+j] = st_r.pc_sel[j] ? (rise[PC0+j] | fall[PC0+j]) // R6 R8
                                             : dma_req_in[j]; // R6
      end
   end

   // Register port, request status and priority pick
   always_comb begin
      logic [11:0] set_v;
      logic [11:0] clr_v;
      logic [11:0] pend;
      logic [1:0]  lvl;
      logic [1:0]  best;
      logic        found;
      logic [3:0]  line;
      logic [3:0]  exc_clr;
      set_v   = ev;
      clr_v   = '0;
      pend    = '0;
      lvl     = '0;
      best    = '0;
      found   = 1'b0;
      line    = '0;
      exc_clr = '0;
      st_nxt  = st_r;
      st_nxt.rdata     = GIS_REG_RST;
      st_nxt.req_pulse = ev; // R14

      if (bus_in.wr) begin
         if (bus_in.addr == GIS_OFS_ALT_SRC) begin
            st_nxt.alt_src = bus_in.wdata & GIS_ALT_WR_MASK; // R3
         end else if (bus_in.addr == GIS_OFS_PORT_SEL) begin
            st_nxt.port_sel = bus_in.wdata;
         end else if (bus_in.addr == GIS_OFS_EDGE_SEL) begin
            st_nxt.edge_sel = bus_in.wdata;
         end else if (bus_in.addr == GIS_OFS_PC_SEL) begin
            st_nxt.pc_sel = bus_in.wdata & GIS_PC_WR_MASK; // R7
         end else if (bus_in.addr == GIS_OFS_STAT_LO) begin
            clr_v[7:0] = bus_in.wdata;
         end else if (bus_in.addr == GIS_OFS_STAT_HI) begin
            clr_v[11:8] = bus_in.wdata[3:0];
         end else if (bus_in.addr == GIS_OFS_SET_LO) begin
            set_v[7:0] = set_v[7:0] | bus_in.wdata; // R10
         end else if (bus_in.addr == GIS_OFS_SET_HI) begin
            set_v[11:8] = set_v[11:8] | bus_in.wdata[3:0]; // R10
         end else if (bus_in.addr == GIS_OFS_EN_LO) begin
            st_nxt.enable[7:0] = bus_in.wdata;
         end else if (bus_in.addr == GIS_OFS_EN_HI) begin
            st_nxt.enable[11:8] = bus_in.wdata[3:0];
         end else if (bus_in.addr == GIS_OFS_PRIO0) begin
            st_nxt.prio[7:0] = bus_in.wdata; // R9
         end else if (bus_in.addr == GIS_OFS_PRIO1) begin
            st_nxt.prio[15:8] = bus_in.wdata; // R9
         end else if (bus_in.addr == GIS_OFS_PRIO2) begin
            st_nxt.prio[23:16] = bus_in.wdata; // R9
         end else if (bus_in.addr == GIS_OFS_CTRL) begin
            st_nxt.polled = bus_in.wdata[GIS_POLL_BIT]; // R12
         end else if (bus_in.addr == GIS_OFS_EXC_STAT) begin
            exc_clr = bus_in.wdata[3:0];
         end
      end

      if (bus_in.rd) begin
         if (bus_in.addr == GIS_OFS_ALT_SRC) begin
            st_nxt.rdata = st_r.alt_src;
         end else if (bus_in.addr == GIS_OFS_PORT_SEL) begin
            st_nxt.rdata = st_r.port_sel;
         end else if (bus_in.addr == GIS_OFS_EDGE_SEL) begin
            st_nxt.rdata = st_r.edge_sel;
         end else if (bus_in.addr == GIS_OFS_PC_SEL) begin
            st_nxt.rdata = st_r.pc_sel;
         end else if (bus_in.addr == GIS_OFS_STAT_LO) begin
            st_nxt.rdata = st_r.status[7:0]; // R12
         end else if (bus_in.addr == GIS_OFS_STAT_HI) begin
            st_nxt.rdata = {4'h0, st_r.status[11:8]}; // R12
         end else if (bus_in.addr == GIS_OFS_EN_LO) begin
            st_nxt.rdata = st_r.enable[7:0];
         end else if (bus_in.addr == GIS_OFS_EN_HI) begin
            st_nxt.rdata = {4'h0, st_r.enable[11:8]};
         end else if (bus_in.addr == GIS_OFS_PRIO0) begin
            st_nxt.rdata = st_r.prio[7:0];
         end else if (bus_in.addr == GIS_OFS_PRIO1) begin
            st_nxt.rdata = st_r.prio[15:8];
         end else if (bus_in.addr == GIS_OFS_PRIO2) begin
            st_nxt.rdata = st_r.prio[23:16];
         end else if (bus_in.addr == GIS_OFS_CTRL) begin
            st_nxt.rdata = {7'h00, st_r.polled};
         end else if (bus_in.addr == GIS_OFS_EXC_STAT) begin
            st_nxt.rdata = {4'h0, st_r.exc_status};
         end
      end

      // Acknowledge clears the vectored line; ignored while polling
      if (ack_in && !st_r.polled && ack_line_in < 4'(GIS_LINES)) begin // R12
         clr_v[ack_line_in] = 1'b1;
      end

      // Set wins over clear
      st_nxt.status     = (st_r.status & ~clr_v) | set_v;
      st_nxt.exc_status = (st_r.exc_status & ~exc_clr) | exc_req_in; // R11

      // Highest level wins, lowest line on a tie; code 3 acts as top level
      pend = st_r.status & st_r.enable;
      for (int k = 0; k < GIS_LINES; k++) begin
         lvl = st_r.prio[2*k +: 2];
         if (lvl > GIS_PRIO_TOP) begin
            lvl = GIS_PRIO_TOP; // R9
         end
         if (pend[k] && (!found || lvl > best)) begin
            found = 1'b1;
            best  = lvl;
            line  = 4'(k);
         end
      end
      st_nxt.vec.valid = found && !st_r.polled; // R12
      st_nxt.vec.level = best;
      st_nxt.vec.line  = line;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_r <= GIS_STATE_RST;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out    = st_r.rdata;
   assign line_req_out = st_r.req_pulse;
   assign vec_out      = st_r.vec;
   assign irq_out      = !st_r.polled && |(st_r.status & st_r.enable); // R12
   assign exc_out      = |st_r.exc_status; // R11

   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence seq_poll_on;
      ce_in && st_r.polled;
   endsequence

   sequence seq_read_stat_lo;
      ce_in && bus_in.rd && bus_in.addr == GIS_OFS_STAT_LO;
   endsequence

   AST_CMP_ROUTE: assert property ( // R1
      ce_in && st_r.alt_src[GIS_CMP_BIT] && (rise[PCMP] || fall[PCMP]) |=> line_req_out[7])
      else $error("comparator edge not routed to line 7");

   AST_CMP_BLOCKS_PIN: assert property ( // R1
      ce_in && st_r.alt_src[GIS_CMP_BIT] && !rise[PCMP] && !fall[PCMP] |=> !line_req_out[7])
      else $error("line 7 fired without comparator edge");

   AST_DBG_ROUTE: assert property ( // R2
      ce_in && st_r.alt_src[GIS_DBG_BIT] && dbg_req_in |=> line_req_out[0])
      else $error("debugger request not routed to line 0");

   AST_DBG_BLOCKS_PIN: assert property ( // R2
      ce_in && st_r.alt_src[GIS_DBG_BIT] && !dbg_req_in |=> !line_req_out[0])
      else $error("line 0 fired without debugger request");

   AST_PORT_D_RISE: assert property ( // R4
      ce_in && st_r.port_sel[3] && st_r.edge_sel[3] && rise[PD0+3] |=> line_req_out[3])
      else $error("port D rising edge lost on line 3");

   AST_FALL_ONLY: assert property ( // R5
      ce_in && !st_r.edge_sel[5] && !st_r.port_sel[5] && rise[PA0+5] |=> !line_req_out[5])
      else $error("rising edge fired a falling-edge line");

   AST_PC_DMA: assert property ( // R6
      ce_in && !st_r.pc_sel[2] && dma_req_in[2] |=> line_req_out[10])
      else $error("DMA request not passed on line 10");

   AST_SW_SET: assert property ( // R10
      ce_in && bus_in.wr && bus_in.addr == GIS_OFS_SET_LO && bus_in.wdata[2]
      |=> st_r.status[2] && (!st_r.enable[2] || st_r.polled || irq_out))
      else $error("software request not raised");

   AST_EXC_NONMASK: assert property ( // R11
      ce_in && exc_req_in[0] |=> exc_out [*1] ##0 st_r.exc_status[0])
      else $error("exception request masked");

   AST_POLL_READ: assert property ( // R12
      seq_poll_on ##0 seq_read_stat_lo |=> !irq_out && !vec_out.valid
      && rdata_out == $past(st_r.status[7:0]))
      else $error("polled mode broke flags or vectoring");

   AST_PRIO_LEVEL: assert property ( // R9
      ce_in && !st_r.polled && st_r.status[9] && st_r.enable[9] && st_r.prio[19:18] == 2'h3
      |=> vec_out.valid && vec_out.level == GIS_PRIO_TOP)
      else $error("priority level not reported");

   sequence seq_cmp_sel;
      ce_in && st_r.alt_src[GIS_CMP_BIT];
   endsequence

   sequence seq_pc1_pin_edge;
      ce_in && st_r.pc_sel[1] && (rise[PC0+1] || fall[PC0+1]);
   endsequence

   AST_CMP_FALL: assert property ( // R13
      seq_cmp_sel ##0 fall[PCMP] |=> line_req_out[7])
      else $error("comparator falling edge not routed to line 7");

   AST_EDGE_ONE_RISE: assert property ( // R14
      ce_in && rise[PCMP] |=> !rise[PCMP])
      else $error("rising edge pulse longer than one cycle");

   AST_EDGE_ONE_FALL: assert property ( // R14
      ce_in && fall[PC0] |=> !fall[PC0])
      else $error("falling edge pulse longer than one cycle");

   AST_PC_PIN: assert property ( // R6
      seq_pc1_pin_edge |=> line_req_out[9])
      else $error("port C pin edge not passed on line 9");

   AST_PC_BLOCKS_DMA: assert property ( // R6
      ce_in && st_r.pc_sel[1] && !rise[PC0+1] && !fall[PC0+1] |=> !line_req_out[9])
      else $error("line 9 fired without port C pin edge");

   AST_DMA_QUIET: assert property ( // R6
      ce_in && !st_r.pc_sel[0] && !dma_req_in[0] |=> !line_req_out[8])
      else $error("line 8 fired without DMA request");

   AST_PORT_A_FALL: assert property ( // R5
      ce_in && !st_r.port_sel[2] && !st_r.edge_sel[2] && fall[PA0+2] |=> line_req_out[2])
      else $error("port A falling edge lost on line 2");

   AST_PORT_A_IGNORED: assert property ( // R4
      ce_in && st_r.port_sel[4] && !rise[PD0+4] && !fall[PD0+4] |=> !line_req_out[4])
      else $error("line 4 fired from the unselected port");

   AST_STATUS_FOLLOWS: assert property ( // R14
      line_req_out[6] |-> st_r.status[6])
      else $error("request pulse did not set its status flag");

   AST_SW_SET_HI: assert property ( // R10
      ce_in && bus_in.wr && bus_in.addr == GIS_OFS_SET_HI && bus_in.wdata[1]
      |=> st_r.status[9])
      else $error("software request on line 9 not raised");

   AST_STAT_HI_READ: assert property ( // R12
      ce_in && bus_in.rd && bus_in.addr == GIS_OFS_STAT_HI
      |=> rdata_out == {4'h0, $past(st_r.status[11:8])})
      else $error("upper request flags not readable");

   AST_EXC_READ: assert property ( // R11
      ce_in && bus_in.rd && bus_in.addr == GIS_OFS_EXC_STAT
      |=> rdata_out == {4'h0, $past(st_r.exc_status)})
      else $error("exception flags not readable");

   AST_EXC_IN_POLL: assert property ( // R11
      ce_in && st_r.polled && exc_req_in[2] |=> exc_out)
      else $error("exception held back in polled mode");

   AST_POLL_NO_VEC: assert property ( // R12
      ce_in && st_r.polled |=> !vec_out.valid)
      else $error("vector offered in polled mode");

   AST_ALT_RESERVED: assert property ( // R3
      ce_in && bus_in.wr && bus_in.addr == GIS_OFS_ALT_SRC
      |=> st_r.alt_src[6:1] == 6'h00)
      else $error("reserved alternate-source bits stored");

endmodule
`default_nettype wire

/* gis_cpu_model.sv */
// Behavioural CPU that acknowledges the vectored request it is offered
`timescale 1ns/10ps
`default_nettype none
module gis_cpu_model
   import gis_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // Requests from the controller, acknowledge enable and hold-off delay
   input  wire logic       irq_in,
   input  wire gis_vec_s   vec_in,
   input  wire logic       ack_en_in,
   input  wire logic [3:0] dly_in,
   // Acknowledge
   output logic            ack_out,
   output logic [3:0]      ack_line_out
);
   logic [3:0] wait_r;

   always_ff @(posedge core_clk_in) begin
      ack_out <= 1'b0;
      // Line number is meaningless outside an acknowledge
      ack_line_out <= ~ack_line_out;
      if (!rst_n_in) begin
         wait_r <= 4'h0;
         ack_line_out <= 4'h0;
      end else if (wait_r != 4'h0) begin
         wait_r <= wait_r - 4'h1;
      end else if (ack_en_in && irq_in && vec_in.valid) begin
         ack_out <= 1'b1;
         ack_line_out <= vec_in.line;
         // Hold off until the vector reflects the cleared line
         wait_r <= dly_in;
      end
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the interrupt source selector
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import gis_pkg::*;
   logic         core_clk_in = 1'b0;
   logic         rst_n_in    = 1'b0;
   logic         ce          = 1'b1;
   gis_bus_req_s bus         = '0;
   gis_pins_s    pins        = '0;
   logic         debug_req   = 1'b0;
   logic [3:0]   dma_req     = 4'h0;
   logic [3:0]   exc_req     = 4'h0;
   logic         ack_en      = 1'b0;
   logic         ack;
   logic [3:0]   ack_line;
   logic [7:0]   rdata;
   logic [11:0]  line_req;
   logic         irq;
   logic         exc;
   gis_vec_s     vec;
   int           bad_count    = 0;
   int           total_checks = 0;
   int           k;

   always #2 core_clk_in = ~core_clk_in;

   gis_irq_sel dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .bus_in(bus), .rdata_out(rdata), .pins_in(pins), .dbg_req_in(debug_req),
      .dma_req_in(dma_req), .exc_req_in(exc_req), .ack_in(ack), .ack_line_in(ack_line),
      .line_req_out(line_req), .irq_out(irq), .vec_out(vec), .exc_out(exc));

   gis_cpu_model cpu (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .irq_in(irq),
      .vec_in(vec), .ack_en_in(ack_en), .dly_in(4'h3), .ack_out(ack),
      .ack_line_out(ack_line));

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk_in);
      bus <= '0;
   endtask

   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge core_clk_in);
      bus <= '0;
      @(negedge core_clk_in);
      chk({4'h0, rdata}, {4'h0, e}, "read data");
   endtask

   // Counts high cycles of one request line over a fixed window
   task automatic pulse(input int ln, input int e);
      int n;
      n = 0;
      repeat (8) begin
         @(negedge core_clk_in);
         if (line_req[ln] === 1'b1) n++;
      end
      chk(n[11:0], e[11:0], "request pulse count");
   endtask

   // Waits a bounded time for the next acknowledge and checks its line
   task automatic wait_ack(input logic [3:0] e);
      int n;
      n = 0;
      while (n < 40 && ack !== 1'b1) begin
         @(negedge core_clk_in);
         n++;
      end
      if (n == 40) begin
         bad_count++;
         $display("BAD %0t no acknowledge offered", $time);
      end
      chk({8'h0, ack_line}, {8'h0, e}, "acknowledged line");
      @(negedge core_clk_in);
   endtask

   // Group 0 port A, 1 port D, 2 port C, other comparator
   task automatic pin(input int g, input int i, input logic v, input int ln, input int e);
      @(posedge core_clk_in);
      case (g)
         0: pins.port_a[i] <= v;
         1: pins.port_d[i] <= v;
         2: pins.port_c[i] <= v;
         default: pins.cmp <= v;
      endcase
      pulse(ln, e);
   endtask

   // Group 0 debugger request, otherwise DMA channel
   task automatic src(input int g, input int i, input int ln, input int e);
      @(posedge core_clk_in);
      if (g == 0) debug_req <= 1'b1;
      else dma_req[i] <= 1'b1;
      @(posedge core_clk_in);
      debug_req <= 1'b0;
      dma_req <= 4'h0;
      pulse(ln, e);
   endtask

   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rd(GIS_OFS_ALT_SRC, 8'h00);
      rd(GIS_OFS_PORT_SEL, 8'h00);
      rd(GIS_OFS_EDGE_SEL, 8'h00);
      rd(GIS_OFS_PC_SEL, 8'h00);
      // Frozen clock enable drops the write
      @(posedge core_clk_in);
      ce <= 1'b0;
      wr(GIS_OFS_PORT_SEL, 8'h3C);
      ce <= 1'b1;
      rd(GIS_OFS_PORT_SEL, 8'h00);
      wr(GIS_OFS_ALT_SRC, 8'hFF);
      rd(GIS_OFS_ALT_SRC, 8'h81);
      wr(GIS_OFS_PC_SEL, 8'hFF);
      rd(GIS_OFS_PC_SEL, 8'h0F);
      wr(GIS_OFS_PORT_SEL, 8'hA5);
      rd(GIS_OFS_PORT_SEL, 8'hA5);
      wr(GIS_OFS_EDGE_SEL, 8'h5A);
      rd(GIS_OFS_EDGE_SEL, 8'h5A);
      wr(24'hFFE10D, 8'hFF);
      rd(24'hFFE10D, 8'h00);
      wr(GIS_OFS_ALT_SRC, 8'h00);
      wr(GIS_OFS_PC_SEL, 8'h00);
      wr(GIS_OFS_PORT_SEL, 8'h00);
      wr(GIS_OFS_EDGE_SEL, 8'h00);
      for (int i = 0; i < 8; i++) begin
         pin(0, i, 1'b1, i, 0);
         pin(0, i, 1'b0, i, 1);
      end
      wr(GIS_OFS_EDGE_SEL, 8'hFF);
      wr(GIS_OFS_PORT_SEL, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         pin(0, i, 1'b1, i, 0);
         pin(1, i, 1'b1, i, 1);
         pin(1, i, 1'b0, i, 0);
         pin(0, i, 1'b0, i, 0);
      end
      wr(GIS_OFS_ALT_SRC, 8'h80);
      pin(1, 7, 1'b1, 7, 0);
      pin(3, 0, 1'b1, 7, 1);
      pin(3, 0, 1'b0, 7, 1);
      wr(GIS_OFS_ALT_SRC, 8'h00);
      pin(1, 7, 1'b0, 7, 0);
      pin(3, 0, 1'b1, 7, 0);
      pin(1, 7, 1'b1, 7, 1);
      wr(GIS_OFS_ALT_SRC, 8'h01);
      pin(1, 0, 1'b1, 0, 0);
      src(0, 0, 0, 1);
      wr(GIS_OFS_ALT_SRC, 8'h00);
      src(0, 0, 0, 0);
      pin(1, 0, 1'b0, 0, 0);
      pin(1, 0, 1'b1, 0, 1);
      for (int i = 0; i < 4; i++) begin
         pin(2, i, 1'b1, 8 + i, 0);
         src(1, i, 8 + i, 1);
      end
      wr(GIS_OFS_PC_SEL, 8'h0F);
      for (int i = 0; i < 4; i++) begin
         pin(2, i, 1'b0, 8 + i, 1);
         pin(2, i, 1'b1, 8 + i, 1);
         src(1, i, 8 + i, 0);
      end
      wr(GIS_OFS_STAT_LO, 8'hFF);
      wr(GIS_OFS_STAT_HI, 8'h0F);
      rd(GIS_OFS_STAT_LO, 8'h00);
      rd(GIS_OFS_STAT_HI, 8'h00);
      // Polled mode keeps flags readable and the CPU line quiet
      wr(GIS_OFS_CTRL, 8'h01);
      wr(GIS_OFS_EN_LO, 8'hFF);
      wr(GIS_OFS_SET_LO, 8'h01);
      rd(GIS_OFS_SET_LO, 8'h00);
      rd(GIS_OFS_STAT_LO, 8'h01);
      chk({11'h0, irq}, 12'h000, "irq in polled mode");
      wr(GIS_OFS_STAT_LO, 8'h01);
      rd(GIS_OFS_STAT_LO, 8'h00);
      @(posedge core_clk_in);
      exc_req <= 4'h4;
      @(posedge core_clk_in);
      exc_req <= 4'h0;
      @(negedge core_clk_in);
      chk({11'h0, exc}, 12'h001, "exception not raised");
      rd(GIS_OFS_EXC_STAT, 8'h04);
      wr(GIS_OFS_EXC_STAT, 8'h04);
      @(negedge core_clk_in);
      chk({11'h0, exc}, 12'h000, "exception not cleared");
      wr(GIS_OFS_CTRL, 8'h00);
      wr(GIS_OFS_SET_HI, 8'h02);
      repeat (2) @(negedge core_clk_in);
      chk({11'h0, irq}, 12'h000, "masked line raised irq");
      wr(GIS_OFS_EN_HI, 8'h0F);
      @(negedge core_clk_in);
      chk({11'h0, irq}, 12'h001, "enabled line lacks irq");
      wr(GIS_OFS_STAT_HI, 8'h02);
      @(negedge core_clk_in);
      chk({11'h0, irq}, 12'h000, "cleared line keeps irq");
      // Line 5 at level 2 outranks line 1 at level 1
      wr(GIS_OFS_PRIO0, 8'h04);
      wr(GIS_OFS_PRIO1, 8'h08);
      // Line 9 code 3 acts as level 2 and ties line 5
      wr(GIS_OFS_PRIO2, 8'h0C);
      wr(GIS_OFS_SET_LO, 8'h22);
      wr(GIS_OFS_SET_HI, 8'h02);
      repeat (3) @(negedge core_clk_in);
      chk({5'h0, vec}, {5'h0, 1'b1, 2'h2, 4'h5}, "vector");
      @(posedge core_clk_in);
      ack_en <= 1'b1;
      wait_ack(4'h5);
      wait_ack(4'h9);
      wait_ack(4'h1);
      for (k = 0; k < 40 && irq !== 1'b0; k++) @(negedge core_clk_in);
      if (k == 40) begin
         bad_count++;
         $display("BAD %0t acknowledge never drained the requests", $time);
      end
      rd(GIS_OFS_STAT_LO, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
